// file: hw/pcg_top.v
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`include "pcg_regs.vh"
module pcg_top #(
  parameter AW           = 12,
  parameter OSC_UP_EDGES = `PCG_OSC_UP_EDGES,
  parameter WDOG_SYNC    = `PCG_WDOG_SYNC_CYC
)(
  input  wire          SYS_CLK,
  input  wire          RST,
  input  wire [AW-1:0] S_AXI_AWADDR,
  input  wire          S_AXI_AWVALID,
  output reg           S_AXI_AWREADY,
  input  wire [31:0]   S_AXI_WDATA,
  input  wire [3:0]    S_AXI_WSTRB,
  input  wire          S_AXI_WVALID,
  output reg           S_AXI_WREADY,
  output reg  [1:0]    S_AXI_BRESP,
  output reg           S_AXI_BVALID,
  input  wire          S_AXI_BREADY,
  input  wire [AW-1:0] S_AXI_ARADDR,
  input  wire          S_AXI_ARVALID,
  output reg           S_AXI_ARREADY,
  output reg  [31:0]   S_AXI_RDATA,
  output reg  [1:0]    S_AXI_RRESP,
  output reg           S_AXI_RVALID,
  input  wire          S_AXI_RREADY,
  input  wire          EXT_OSC_CLK,
  input  wire          SPECIAL_MODE,
  input  wire          STOP_MODE,
  output reg           PLL_CLK_EN,
  output reg           BUS_CLK_EN,
  output reg           LOCK_IRQ,
  output reg           OSC_ENABLE,
  output reg           OSC_MON_RST_EN,
  output reg           OSC_FULL_SWING,
  output reg           WDOG_RUN
);
  localparam IRC_DIV = `PCG_IRC_CYC - 1;

  reg  [AW-1:0] awaddr_q;
  reg  [7:0]    wdata_q;
  reg           wlane_q;
  reg           aw_full_q;
  reg           w_full_q;
  reg  [7:0]    synth_q;
  reg  [7:0]    ref_divider_q;
  reg  [4:0]    post_q;
  reg  [7:0]    trimh_q;
  reg  [7:0]    triml_q;
  reg  [7:0]    test_q;
  reg  [1:0]    osc2_q;
  reg           guard_active_q;
  reg           pll_bus_source_sel_q;
  reg           osc_en_q;
  reg           lock_ie_q;
  reg           wd_rc_q;
  reg           wd_sa_q;
  reg           osc_stable_q;
  reg  [12:0]   osc_up_cnt_q;
  reg  [2:0]    osc_sync_q;
  reg           lock_prev_q;
  reg  [15:0]   vco_phase_q;
  reg           vco_tick_q;
  reg  [15:0]   vco_step_q;
  reg  [7:0]    wd_cnt_q;
  reg           wr_map;
  reg  [7:0]    rd_byte;
  reg           rd_map;

  wire [9:0] widx = awaddr_q[11:2];
  wire [9:0] ridx = S_AXI_ARADDR[11:2];
  wire wr_go  = aw_full_q & w_full_q & ~S_AXI_BVALID;
  wire we     = wr_go & wlane_q & wr_map;
  wire open_g = ~guard_active_q;
  wire osc1_wr = we & (widx == `PCG_IDX_OSC1) & open_g & pll_bus_source_sel_q;
  wire osc_edge = osc_sync_q[1] & ~osc_sync_q[2];
  wire irc_tick;
  wire osc_ref_tick;
  wire fb_tick;
  wire pll_tick;
  wire bus_tick;
  wire locked;
  wire speed_up;
  wire slow_down;
  wire ref_tick = osc_en_q ? osc_ref_tick : irc_tick;
  wire [4:0] post_eff = locked ? post_q : `PCG_UNLOCK_POST;
  wire [16:0] phase_sum = {1'b0, vco_phase_q} + {1'b0, vco_step_q};

  // The second and third stages feed the edge detector
  always @(posedge SYS_CLK or posedge RST) begin
    if (RST)
      osc_sync_q <= 3'h0;
    else
      osc_sync_q <= {osc_sync_q[1:0], EXT_OSC_CLK};
  end

  always @* begin
    case (widx)
      `PCG_IDX_WDOG, `PCG_IDX_SYNTH, `PCG_IDX_REF_DIVIDER, `PCG_IDX_CLKSEL,
      `PCG_IDX_PLLCTL, `PCG_IDX_TRIMH, `PCG_IDX_TRIML, `PCG_IDX_OSC1,
      `PCG_IDX_GUARD, `PCG_IDX_TEST, `PCG_IDX_STATUS, `PCG_IDX_OSC2:
        wr_map = 1'b1;
      default: wr_map = 1'b0;
    endcase
  end

  always @* begin
    rd_map  = 1'b1;
    rd_byte = 8'h00;
    case (ridx)
      `PCG_IDX_WDOG:   rd_byte = {6'h0, wd_sa_q, wd_rc_q};
      `PCG_IDX_SYNTH:  rd_byte = synth_q;
      `PCG_IDX_REF_DIVIDER: rd_byte = ref_divider_q;
      `PCG_IDX_CLKSEL: rd_byte = {pll_bus_source_sel_q, 7'h0};
      `PCG_IDX_PLLCTL: rd_byte = {3'h0, post_q};
      `PCG_IDX_TRIMH:  rd_byte = trimh_q;
      `PCG_IDX_TRIML:  rd_byte = triml_q;
      `PCG_IDX_OSC1:   rd_byte = {osc_en_q, 7'h0};
      `PCG_IDX_GUARD:  rd_byte = {7'h0, guard_active_q};
      `PCG_IDX_TEST:   rd_byte = test_q;
      `PCG_IDX_STATUS: rd_byte = {lock_ie_q, 5'h0, osc_stable_q, locked};
      `PCG_IDX_OSC2:   rd_byte = {6'h0, osc2_q};
      default:         rd_map  = 1'b0;
    endcase
  end

  // Bus slave; one write and one read in flight
  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= 2'b00;
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RRESP   <= 2'b00;
      S_AXI_RDATA   <= 32'h0;
      aw_full_q     <= 1'b0;
      w_full_q      <= 1'b0;
      awaddr_q      <= {AW{1'b0}};
      wdata_q       <= 8'h00;
      wlane_q       <= 1'b0;
    end else begin
      S_AXI_AWREADY <= ~aw_full_q & ~(S_AXI_AWVALID & S_AXI_AWREADY);
      S_AXI_WREADY  <= ~w_full_q & ~(S_AXI_WVALID & S_AXI_WREADY);
      S_AXI_ARREADY <= ~S_AXI_RVALID & ~(S_AXI_ARVALID & S_AXI_ARREADY);
      if (S_AXI_AWVALID & S_AXI_AWREADY) begin
        aw_full_q <= 1'b1;
        awaddr_q  <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID & S_AXI_WREADY) begin
        w_full_q <= 1'b1;
        wdata_q  <= S_AXI_WDATA[7:0];
        wlane_q  <= S_AXI_WSTRB[0];
      end
      if (wr_go) begin
        S_AXI_BVALID <= 1'b1;
        // Guarded writes still answer OKAY
        S_AXI_BRESP  <= wr_map ? 2'b00 : 2'b10;
      end else if (S_AXI_BVALID & S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
        aw_full_q    <= 1'b0;
        w_full_q     <= 1'b0;
      end
      if (S_AXI_ARVALID & S_AXI_ARREADY) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA  <= {24'h0, rd_byte};
        S_AXI_RRESP  <= rd_map ? 2'b00 : 2'b10;
      end else if (S_AXI_RVALID & S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  // Register writes
  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      guard_active_q <= 1'b0;
      synth_q        <= `PCG_RST_SYNTH;
      ref_divider_q       <= `PCG_RST_REF_DIVIDER;
      post_q         <= `PCG_RST_POST;
      trimh_q        <= `PCG_RST_TRIMH;
      triml_q        <= `PCG_RST_TRIML;
      test_q         <= 8'h00;
      osc2_q         <= 2'b00;
      pll_bus_source_sel_q       <= 1'b1;
      osc_en_q       <= 1'b0;
      lock_ie_q      <= 1'b0;
      wd_rc_q        <= 1'b0;
      wd_sa_q        <= 1'b0;
    end else begin
      if (we) begin
        case (widx)
          `PCG_IDX_GUARD:
            guard_active_q <= (wdata_q != `PCG_GUARD_KEY);
          `PCG_IDX_SYNTH:  if (open_g) synth_q <= wdata_q;
          `PCG_IDX_REF_DIVIDER:
            if (open_g) ref_divider_q <= {wdata_q[7:6], 2'b00, wdata_q[3:0]};
          `PCG_IDX_CLKSEL:
            if (open_g) pll_bus_source_sel_q <= wdata_q[`PCG_B_PLL_BUS_SOURCE_SEL];
          `PCG_IDX_PLLCTL: if (open_g) post_q <= wdata_q[4:0];
          `PCG_IDX_TRIMH:  if (open_g) trimh_q <= wdata_q;
          `PCG_IDX_TRIML:  if (open_g) triml_q <= wdata_q;
          `PCG_IDX_OSC1:
            if (open_g & pll_bus_source_sel_q) osc_en_q <= wdata_q[`PCG_B_OSCEN];
          `PCG_IDX_TEST:   if (SPECIAL_MODE) test_q <= wdata_q;
          `PCG_IDX_OSC2:
            if (open_g & pll_bus_source_sel_q & ~osc_en_q)
              osc2_q <= wdata_q[1:0];
          `PCG_IDX_STATUS: lock_ie_q <= wdata_q[`PCG_B_LOCK_IRQ_EN];
          `PCG_IDX_WDOG: begin
            wd_rc_q <= wdata_q[`PCG_B_WD_RC];
            wd_sa_q <= wdata_q[`PCG_B_WD_SA];
          end
          default: ;
        endcase
      end
      // Bus leaves the oscillator while it is enabled but not yet stable
      if (~pll_bus_source_sel_q & ~osc_stable_q & osc_en_q)
        pll_bus_source_sel_q <= 1'b1;
    end
  end

  // Oscillator start-up qualification
  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      osc_stable_q <= 1'b0;
      osc_up_cnt_q <= 13'h0;
      lock_prev_q  <= 1'b0;
      LOCK_IRQ     <= 1'b0;
    end else begin
      lock_prev_q <= locked;
      LOCK_IRQ    <= lock_ie_q & (locked != lock_prev_q);
      if (osc1_wr | ~osc_en_q | (lock_prev_q & ~locked)) begin
        osc_stable_q <= 1'b0;
        osc_up_cnt_q <= 13'h0;
      end else if (osc_edge & ~osc_stable_q) begin
        if (osc_up_cnt_q >= OSC_UP_EDGES[12:0] - 13'h1)
          osc_stable_q <= locked;
        else
          osc_up_cnt_q <= osc_up_cnt_q + 13'h1;
      end
    end
  end

  // VCO modelled as a phase accumulator; tops out at SYS_CLK
  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      vco_phase_q <= 16'h0;
      vco_tick_q  <= 1'b0;
      vco_step_q  <= `PCG_VCO_STEP;
    end else begin
      vco_phase_q <= phase_sum[15:0];
      vco_tick_q  <= phase_sum[16];
      if (speed_up && vco_step_q <= 16'hffff - `PCG_VCO_GAIN)
        vco_step_q <= vco_step_q + `PCG_VCO_GAIN;
      else if (slow_down && vco_step_q > `PCG_VCO_GAIN)
        vco_step_q <= vco_step_q - `PCG_VCO_GAIN;
    end
  end

  pcg_tickdiv #(.W(7)) u_irc (
    .clk(SYS_CLK), .rst(RST), .tick_in(1'b1),
    .div(IRC_DIV[6:0]), .tick_out(irc_tick));

  pcg_tickdiv #(.W(4)) u_ref_divider (
    .clk(SYS_CLK), .rst(RST), .tick_in(osc_edge),
    .div(ref_divider_q[3:0]), .tick_out(osc_ref_tick));

  // Feedback runs at twice the reference when on target
  pcg_tickdiv #(.W(6)) u_fbdiv (
    .clk(SYS_CLK), .rst(RST), .tick_in(vco_tick_q),
    .div(synth_q[5:0]), .tick_out(fb_tick));

  pcg_tickdiv #(.W(5)) u_post (
    .clk(SYS_CLK), .rst(RST), .tick_in(vco_tick_q),
    .div(post_eff), .tick_out(pll_tick));

  pcg_tickdiv #(.W(1)) u_bus (
    .clk(SYS_CLK), .rst(RST),
    .tick_in(pll_bus_source_sel_q ? pll_tick : osc_edge),
    .div(1'b1), .tick_out(bus_tick));

  pcg_lockdet u_lock (
    .clk(SYS_CLK), .rst(RST), .ref_tick(ref_tick), .fb_tick(fb_tick),
    .clr(osc1_wr), .locked(locked), .speed_up(speed_up),
    .slow_down(slow_down));

  // Outputs and watchdog restart
  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      PLL_CLK_EN     <= 1'b0;
      BUS_CLK_EN     <= 1'b0;
      OSC_ENABLE     <= 1'b0;
      OSC_MON_RST_EN <= 1'b0;
      OSC_FULL_SWING <= 1'b0;
      WDOG_RUN       <= 1'b1;
      wd_cnt_q       <= 8'h0;
    end else begin
      PLL_CLK_EN     <= pll_tick;
      BUS_CLK_EN     <= bus_tick;
      OSC_ENABLE     <= osc_en_q;
      OSC_MON_RST_EN <= osc_en_q & osc2_q[`PCG_B_OSC_MONITOR_RESET_EN];
      OSC_FULL_SWING <= osc2_q[`PCG_B_OSC_AMPLITUDE_MODE];
      if (STOP_MODE) begin
        WDOG_RUN <= 1'b0;
        wd_cnt_q <= (wd_rc_q & wd_sa_q) ? WDOG_SYNC[7:0] : 8'h0;
      end else if (wd_cnt_q != 8'h0) begin
        wd_cnt_q <= wd_cnt_q - 8'h1;
      end else begin
        WDOG_RUN <= 1'b1;
      end
    end
  end
endmodule

// file: hw/pcg_regs.vh
`ifndef PCG_REGS_VH
`define PCG_REGS_VH
// Register indices; byte address is four times the index
`define PCG_IDX_WDOG    10'h2f3
`define PCG_IDX_SYNTH   10'h2f4
`define PCG_IDX_REF_DIVIDER  10'h2f5
`define PCG_IDX_CLKSEL  10'h2f6
`define PCG_IDX_PLLCTL  10'h2f7
`define PCG_IDX_TRIMH   10'h2f8
`define PCG_IDX_TRIML   10'h2f9
`define PCG_IDX_OSC1    10'h2fa
`define PCG_IDX_GUARD   10'h2fb
`define PCG_IDX_TEST    10'h2fc
`define PCG_IDX_STATUS  10'h2fd
`define PCG_IDX_OSC2    10'h2fe
// Field positions
`define PCG_B_PLL_BUS_SOURCE_SEL    7
`define PCG_B_OSCEN     7
`define PCG_B_OSC_MONITOR_RESET_EN      1
`define PCG_B_OSC_AMPLITUDE_MODE    0
`define PCG_B_LOCK      0
`define PCG_B_OSCUP     1
`define PCG_B_LOCK_IRQ_EN    7
`define PCG_B_WD_RC     0
`define PCG_B_WD_SA     1
// Reset values and key
`define PCG_GUARD_KEY   8'h26
`define PCG_RST_SYNTH   8'h58
`define PCG_RST_REF_DIVIDER  8'h00
`define PCG_RST_POST    5'h03
`define PCG_UNLOCK_POST 5'h03
`define PCG_RST_TRIMH   8'h00
`define PCG_RST_TRIML   8'h00
// Timing
`define PCG_SYS_FREQ_HZ 100000000
`define PCG_IRC_FREQ_HZ 1000000
`define PCG_IRC_CYC     (`PCG_SYS_FREQ_HZ / `PCG_IRC_FREQ_HZ)
`define PCG_VCO_STEP    16'h8000
`define PCG_VCO_GAIN    16'h0040
`define PCG_FB_PER_REF  4'h2
`define PCG_LOCK_PERIODS 4
`define PCG_OSC_UP_EDGES 4096
`define PCG_WDOG_SYNC_CYC 8
`endif

// file: hw/pcg_tickdiv.v
`timescale 1ns/1ps
module pcg_tickdiv #(
  parameter W = 6
)(
  input  wire         clk,
  input  wire         rst,
  input  wire         tick_in,
  input  wire [W-1:0] div,
  output reg          tick_out
);
  reg [W-1:0] cnt_q;

  // Emits one tick per div+1 input ticks
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q    <= {W{1'b0}};
      tick_out <= 1'b0;
    end else begin
      tick_out <= 1'b0;
      if (tick_in) begin
        if (cnt_q >= div) begin
          cnt_q    <= {W{1'b0}};
          tick_out <= 1'b1;
        end else begin
          cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule

// file: hw/pcg_lockdet.v
`timescale 1ns/1ps
`include "pcg_regs.vh"
module pcg_lockdet #(
  parameter LOCK_PERIODS = `PCG_LOCK_PERIODS
)(
  input  wire clk,
  input  wire rst,
  input  wire ref_tick,
  input  wire fb_tick,
  input  wire clr,
  output reg  locked,
  output reg  speed_up,
  output reg  slow_down
);
  reg  [3:0] fb_cnt_q;
  reg  [3:0] match_q;
  wire [3:0] n = fb_cnt_q + {3'h0, fb_tick};

  // Feedback edges counted per reference period
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      fb_cnt_q  <= 4'h0;
      match_q   <= 4'h0;
      locked    <= 1'b0;
      speed_up  <= 1'b0;
      slow_down <= 1'b0;
    end else begin
      speed_up  <= 1'b0;
      slow_down <= 1'b0;
      if (clr) begin
        fb_cnt_q <= 4'h0;
        match_q  <= 4'h0;
        locked   <= 1'b0;
      end else if (ref_tick) begin
        fb_cnt_q  <= 4'h0;
        speed_up  <= (n < `PCG_FB_PER_REF);
        slow_down <= (n > `PCG_FB_PER_REF);
        if (n == `PCG_FB_PER_REF) begin
          if (match_q >= LOCK_PERIODS[3:0] - 4'h1)
            locked <= 1'b1;
          else
            match_q <= match_q + 4'h1;
        end else begin
          match_q <= 4'h0;
          // Wider unlock window gives hysteresis
          if (n + 4'h1 < `PCG_FB_PER_REF || n > `PCG_FB_PER_REF + 4'h1)
            locked <= 1'b0;
        end
      end else if (fb_tick && fb_cnt_q != 4'hf) begin
        fb_cnt_q <= n;
      end
    end
  end
endmodule

// file: verification/pcg_top_asserts.sv
`timescale 1ns/1ps
module pcg_top_asserts #(
  parameter AW = 12
)(
  input logic          SYS_CLK,
  input logic          RST,
  input logic [AW-1:0] S_AXI_AWADDR,
  input logic          S_AXI_AWVALID,
  input logic          S_AXI_AWREADY,
  input logic          S_AXI_WVALID,
  input logic          S_AXI_WREADY,
  input logic [1:0]    S_AXI_BRESP,
  input logic          S_AXI_BVALID,
  input logic          STOP_MODE,
  input logic          PLL_CLK_EN,
  input logic          BUS_CLK_EN,
  input logic          LOCK_IRQ,
  input logic          OSC_ENABLE,
  input logic          OSC_MON_RST_EN,
  input logic          OSC_FULL_SWING,
  input logic          WDOG_RUN
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  // Dividers keep reset values until software raises the first write
  logic aw_seen_q;
  always @(posedge SYS_CLK or posedge RST) begin
    if (RST)
      aw_seen_q <= 1'b0;
    else if (S_AXI_AWVALID)
      aw_seen_q <= 1'b1;
  end

  sequence s_wr_taken;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  // Mapped window only; unmapped words answer with an error
  sequence s_wr_mapped;
    s_wr_taken ##0 (S_AXI_AWADDR[AW-1:2] >= 10'h2f3
      && S_AXI_AWADDR[AW-1:2] <= 10'h2fe);
  endsequence

  chk_mapped_okay: assert property (s_wr_mapped |=> ##1
    (S_AXI_BVALID && S_AXI_BRESP == 2'b00))
    else $error("mapped write not answered okay");
  chk_irq_one_pulse: assert property (LOCK_IRQ |=> !LOCK_IRQ)
    else $error("lock request longer than one cycle");
  // Reset post value gives VCO/4 and VCO tops out at SYS_CLK
  // Only before any write; a write in flight shortens the bus margin
  chk_pll_min_gap: assert property (PLL_CLK_EN && !aw_seen_q
    && !S_AXI_AWVALID |=> !PLL_CLK_EN [*3])
    else $error("PLL tick too soon");
  chk_bus_min_gap: assert property (BUS_CLK_EN && !aw_seen_q
    && !S_AXI_AWVALID |=> !BUS_CLK_EN [*5])
    else $error("bus tick too soon");
  chk_mon_needs_osc: assert property (OSC_MON_RST_EN |-> OSC_ENABLE)
    else $error("monitor reset without oscillator");
  chk_swing_by_write: assert property ($changed(OSC_FULL_SWING) |->
    S_AXI_BVALID || $past(S_AXI_BVALID))
    else $error("amplitude mode changed without a write");
  chk_stop_halts: assert property (STOP_MODE |=> !WDOG_RUN)
    else $error("watchdog runs in stop");
  chk_wdog_resume: assert property ($fell(STOP_MODE) |->
    ##[1:12] WDOG_RUN)
    else $error("watchdog not resumed after stop");
endmodule

bind pcg_top pcg_top_asserts #(.AW(AW)) pcg_top_asserts_inst (
  .SYS_CLK(SYS_CLK), .RST(RST), .S_AXI_AWADDR(S_AXI_AWADDR),
  .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
  .STOP_MODE(STOP_MODE), .PLL_CLK_EN(PLL_CLK_EN),
  .BUS_CLK_EN(BUS_CLK_EN), .LOCK_IRQ(LOCK_IRQ), .OSC_ENABLE(OSC_ENABLE),
  .OSC_MON_RST_EN(OSC_MON_RST_EN), .OSC_FULL_SWING(OSC_FULL_SWING),
  .WDOG_RUN(WDOG_RUN)
);

// file: verification/pll_clock_config_guard_bench.sv
`timescale 1ns/1ps
`include "pcg_regs.vh"
`define CHK(nm, e, a) begin \
  num_checks++; \
  if ((a) !== (e)) begin \
    failures++; \
    $display("[ERR] %s exp %h got %h", nm, e, a); \
  end \
end
module pll_clock_config_guard_bench;
  localparam WSYNC = 2;
  logic        clk, rst, awvalid, wvalid, bready, arvalid, rready;
  logic        osc, spec, stop, aw_rdy, w_rdy, b_vld, ar_rdy, r_vld;
  logic        pll_en, bus_en, irq, osc_en, mon_en, swing, wd_run;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, r_data;
  logic [1:0]  b_resp, r_resp, bsp, rsp;
  int          failures = 0, num_checks = 0, irq_cnt = 0, oc = 0;
  int          pll_cnt = 0, bus_cnt = 0;
  // Table of protected registers and their reset values
  logic [9:0]  idx_t [8] = '{`PCG_IDX_SYNTH, `PCG_IDX_REF_DIVIDER,
    `PCG_IDX_CLKSEL, `PCG_IDX_PLLCTL, `PCG_IDX_TRIMH, `PCG_IDX_TRIML,
    `PCG_IDX_OSC1, `PCG_IDX_OSC2};
  logic [7:0]  rst_t [8] = '{8'h58, 8'h00, 8'h80, 8'h03, 8'h00, 8'h00,
    8'h00, 8'h00};

  pcg_top #(.OSC_UP_EDGES(4), .WDOG_SYNC(WSYNC)) pcg_top_inst (
    .SYS_CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(aw_rdy), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(4'h1), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(w_rdy),
    .S_AXI_BRESP(b_resp), .S_AXI_BVALID(b_vld), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(ar_rdy), .S_AXI_RDATA(r_data), .S_AXI_RRESP(r_resp),
    .S_AXI_RVALID(r_vld), .S_AXI_RREADY(rready), .EXT_OSC_CLK(osc),
    .SPECIAL_MODE(spec), .STOP_MODE(stop), .PLL_CLK_EN(pll_en),
    .BUS_CLK_EN(bus_en), .LOCK_IRQ(irq), .OSC_ENABLE(osc_en),
    .OSC_MON_RST_EN(mon_en), .OSC_FULL_SWING(swing), .WDOG_RUN(wd_run));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Crystal at 1 MHz so the reference keeps its rate when switched
  always @(posedge clk) begin
    oc <= (oc == 49) ? 0 : oc + 1;
    if (oc == 49) osc <= ~osc;
    if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
    if (pll_en === 1'b1) pll_cnt <= pll_cnt + 1;
    if (bus_en === 1'b1) bus_cnt <= bus_cnt + 1;
  end

  task automatic wr(input logic [9:0] i, input logic [7:0] d);
    @(posedge clk);
    awaddr <= {i, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && aw_rdy) awvalid <= 1'b0;
      if (wvalid && w_rdy) wvalid <= 1'b0;
    end while (!(bready && b_vld));
    bsp = b_resp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [9:0] i, output logic [7:0] d);
    @(posedge clk);
    araddr <= {i, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && ar_rdy) arvalid <= 1'b0;
    end while (!(rready && r_vld));
    d = r_data[7:0];
    rsp = r_resp;
    rready <= 1'b0;
  endtask

  task automatic t_reset;
    logic [7:0] v;
    for (int k = 0; k < 8; k++) begin
      rd(idx_t[k], v);
      `CHK("reset value", rst_t[k], v)
    end
    rd(`PCG_IDX_GUARD, v);
    `CHK("guard reset", 8'h00, v)
    rd(10'h000, v);
    `CHK("unmapped resp", 2'b10, rsp)
    $display("done: reset values");
  endtask

  task automatic t_guard;
    logic [7:0] v;
    logic [7:0] keys [3] = '{8'h00, 8'h27, 8'hff};
    for (int k = 0; k < 3; k++) begin
      wr(`PCG_IDX_GUARD, keys[k]);
      rd(`PCG_IDX_GUARD, v);
      `CHK("guard set", 8'h01, v)
    end
    for (int k = 0; k < 8; k++) begin
      wr(idx_t[k], ~rst_t[k]);
      `CHK("blocked okay", 2'b00, bsp)
      rd(idx_t[k], v);
      `CHK("blocked write", rst_t[k], v)
    end
    wr(`PCG_IDX_GUARD, `PCG_GUARD_KEY);
    rd(`PCG_IDX_GUARD, v);
    `CHK("guard clear", 8'h00, v)
    wr(`PCG_IDX_PLLCTL, 8'h07);
    rd(`PCG_IDX_PLLCTL, v);
    `CHK("open write", 8'h07, v)
    wr(`PCG_IDX_PLLCTL, 8'h03);
    $display("done: guard");
  endtask

  task automatic t_test_reg;
    logic [7:0] v;
    wr(`PCG_IDX_TEST, 8'h5a);
    rd(`PCG_IDX_TEST, v);
    `CHK("test normal", 8'h00, v)
    spec <= 1'b1;
    wr(`PCG_IDX_TEST, 8'h5a);
    rd(`PCG_IDX_TEST, v);
    `CHK("test special", 8'h5a, v)
    wr(`PCG_IDX_TEST, 8'h00);
    spec <= 1'b0;
    $display("done: test register");
  endtask

  // Only the 40000-cycle time limit ends a lock that never comes
  task automatic wait_lock;
    logic [7:0] v;
    do begin
      rd(`PCG_IDX_STATUS, v);
    end while (v[0] !== 1'b1);
  endtask

  task automatic t_lock;
    logic [7:0] v;
    int p0, b0, pn, bn;
    wr(`PCG_IDX_SYNTH, 8'h58);
    wr(`PCG_IDX_REF_DIVIDER, 8'h00);
    wait_lock();
    `CHK("irq masked", 0, irq_cnt)
    wr(`PCG_IDX_STATUS, 8'h80);
    rd(`PCG_IDX_STATUS, v);
    `CHK("lock ro", 2'b11, {v[7], v[0]})
    wr(`PCG_IDX_OSC1, 8'h00);
    rd(`PCG_IDX_STATUS, v);
    `CHK("osc1 clears", 2'b00, v[1:0])
    `CHK("irq on loss", 1, irq_cnt)
    wait_lock();
    // Request pulse trails the lock bit by a cycle
    repeat (2) @(posedge clk);
    `CHK("irq on lock", 2, irq_cnt)
    wr(`PCG_IDX_STATUS, 8'h00);
    p0 = pll_cnt;
    b0 = bus_cnt;
    repeat (800) @(posedge clk);
    pn = pll_cnt - p0;
    bn = bus_cnt - b0;
    // 50 MHz VCO over post 3 gives a tick every 8 cycles
    `CHK("pll rate", 1'b1, pn >= 95 && pn <= 105)
    `CHK("bus half", 1'b1, pn - 2 * bn >= -2 && pn - 2 * bn <= 2)
    $display("done: lock");
  endtask

  task automatic t_osc2;
    logic [7:0] v;
    wr(`PCG_IDX_OSC2, 8'h03);
    rd(`PCG_IDX_OSC2, v);
    `CHK("osc2 open", 8'h03, v)
    `CHK("full swing", 1'b1, swing)
    `CHK("monitor off", 1'b0, mon_en)
    wr(`PCG_IDX_GUARD, 8'h00);
    wr(`PCG_IDX_OSC2, 8'h00);
    rd(`PCG_IDX_OSC2, v);
    `CHK("osc2 guarded", 8'h03, v)
    wr(`PCG_IDX_GUARD, `PCG_GUARD_KEY);
    wr(`PCG_IDX_OSC1, 8'h80);
    wr(`PCG_IDX_OSC2, 8'h00);
    rd(`PCG_IDX_OSC2, v);
    `CHK("osc2 osc on", 8'h03, v)
    `CHK("osc enabled", 1'b1, osc_en)
    `CHK("monitor on", 1'b1, mon_en)
    wr(`PCG_IDX_OSC1, 8'h00);
    wr(`PCG_IDX_OSC2, 8'h01);
    rd(`PCG_IDX_OSC2, v);
    `CHK("osc2 mode", 8'h01, v)
    `CHK("monitor clr", 1'b0, mon_en)
    $display("done: oscillator two");
  endtask

  task automatic stop_cycle(output int n);
    @(posedge clk);
    stop <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK("wdog halted", 1'b0, wd_run)
    stop <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wd_run !== 1'b1 && n < 50);
  endtask

  task automatic t_wdog;
    int n0, n1;
    wr(`PCG_IDX_STATUS, 8'h00);
    wr(`PCG_IDX_WDOG, 8'h00);
    stop_cycle(n0);
    wr(`PCG_IDX_WDOG, 8'h03);
    stop_cycle(n1);
    `CHK("wdog delay", WSYNC, n1 - n0)
    $display("done: watchdog");
  endtask

  task automatic test_done;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Tests need a few thousand cycles
  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    test_done();
  end

  initial begin
    {awvalid, wvalid, bready, arvalid, rready, osc, spec, stop} = 8'h00;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_guard();
    t_test_reg();
    t_lock();
    t_osc2();
    t_wdog();
    test_done();
  end
endmodule
